/* core/ismp_ctrl.sv */
// Contract
// - thirty-two vectored lines, each its own vector
// - four priority levels, mask at or below level
// - any combined source flag raises its line
// - line position implies no priority beyond number
// - lines 0-11 from port0 wake pins
// - line 12 from port1 pin0 wake
// - line 13 CAN, only on CAN variants
// - line 14 serial port b, 15 two-wire
// - late higher request preempts entry, no restart
// - lines 16-31 timers, serial, adc, gpio
`timescale 1ns/1ps
`default_nettype none
module ismp_ctrl #(
    parameter bit HAS_CAN = 1'b1
) (
    input  wire logic                               clk_sys,   // system clock
    input  wire logic                               resetn,    // async reset, low
    input  wire logic                               clk_en,    // freezes state when low
    input  wire ismp_pkg::ismp_src_t                src,       // raw source flags
    input  wire logic [ismp_pkg::NUM_LINES-1:0]     line_en,   // per-line enable
    input  wire logic [ismp_pkg::NUM_LINES*ismp_pkg::PRIO_W-1:0] line_prio, // per-line prio
    input  wire logic [ismp_pkg::PRIO_W-1:0]        mask_lvl,  // prio at/above masked
    input  wire logic                               mask_on,   // masking level active
    input  wire logic [ismp_pkg::NUM_LINES-1:0]     pend_clr,  // software clear pulses
    input  wire logic                               cpu_ack,   // entry finished
    input  wire logic                               cpu_eoi,   // handler returned
    output logic                                    irq_req,   // request to core
    output logic [ismp_pkg::ID_W-1:0]               irq_id,    // vector number
    output logic                                    irq_taken  // one-cycle: entry accepted
);
    ismp_pkg::ismp_regs_t r_r;
    ismp_pkg::ismp_regs_t r_nxt;
    logic [ismp_pkg::NUM_LINES-1:0] lines;
    ismp_pkg::ismp_src_t            src_q;

    // raw flags are synchronised one by one before any or-ing, so a
    // glitch between two unrelated flags never reaches a sync stage
    assign src_q = r_r.src_s2;

    // map flags onto lines; reserved lines 22,23,27 stay low
    always_comb begin
        lines = '0;
        lines[ismp_pkg::WAKE_P0_N-1:0] = src_q.port0_wake;
        lines[ismp_pkg::LINE_WAKE1]  = src_q.port1_pin0_wake;
        lines[ismp_pkg::LINE_CAN]    = HAS_CAN & src_q.can_irq;
        lines[ismp_pkg::LINE_SSPB]   = |src_q.sync_serial_port_b;
        lines[ismp_pkg::LINE_TWI]    = src_q.twi_state_chg;
        lines[ismp_pkg::LINE_TMR16A] = |src_q.tmr16a;
        lines[ismp_pkg::LINE_TMR16B] = |src_q.tmr16b;
        lines[ismp_pkg::LINE_TMR32A] = |src_q.tmr32a;
        lines[ismp_pkg::LINE_TMR32B] = |src_q.tmr32b;
        lines[ismp_pkg::LINE_SSPA]   = |src_q.sync_serial_port_a;
        lines[ismp_pkg::LINE_UART]   = |src_q.uart;
        lines[ismp_pkg::LINE_ADC]    = src_q.adc_done;
        lines[ismp_pkg::LINE_WDT]    = src_q.wdt_irq;
        lines[ismp_pkg::LINE_BOD]    = src_q.bod_irq;
        // gpio port 3 on 28 down to port 0 on 31
        for (int g = 0; g < ismp_pkg::GPIO_N; g++) begin
            lines[ismp_pkg::LINE_GPIO3+g] = src_q.gpio_port_irq[ismp_pkg::GPIO_N-1-g];
        end
    end

    // arbitration: lowest prio value wins, ties to lowest line number
    logic                        win_v;
    logic [ismp_pkg::ID_W-1:0]   win_id;
    logic [ismp_pkg::PRIO_W-1:0] win_p;
    logic [ismp_pkg::PRIO_W-1:0] p;
    always_comb begin
        win_v  = 1'b0;
        win_id = '0;
        win_p  = ismp_pkg::PRIO_NONE;
        p      = '0;
        for (int i = 0; i < ismp_pkg::NUM_LINES; i++) begin
            p = line_prio[i*ismp_pkg::PRIO_W +: ismp_pkg::PRIO_W];
            // masked when prio value not more urgent than mask level
            if (r_r.pend[i] && line_en[i] && !(mask_on && p >= mask_lvl)
                && (!win_v || p < win_p)) begin
                win_v  = 1'b1;
                win_id = ismp_pkg::ID_W'(i);
                win_p  = p;
            end
        end
    end

    // next-state
    always_comb begin
        r_nxt        = r_r;
        r_nxt.taken  = 1'b0;
        r_nxt.src_s1 = src;
        r_nxt.src_s2 = r_r.src_s1;
        // set beats clear so no event is lost
        r_nxt.pend   = (r_r.pend & ~pend_clr) | lines;
        case (r_r.st)
            ismp_pkg::ST_IDLE: begin
                if (win_v) begin
                    r_nxt.st       = ismp_pkg::ST_ENTRY;
                    r_nxt.req      = 1'b1;
                    r_nxt.req_id   = win_id;
                    r_nxt.cur_id   = win_id;
                    r_nxt.cur_prio = win_p;
                end
            end
            ismp_pkg::ST_ENTRY: begin
                // ack closes entry on the vector the core has fetched; a
                // swap in the ack cycle would clear a line never serviced
                if (cpu_ack) begin
                    r_nxt.st    = ismp_pkg::ST_ACTIVE;
                    r_nxt.req   = 1'b0;
                    r_nxt.taken = 1'b1;
                    r_nxt.pend[r_r.cur_id] = lines[r_r.cur_id];
                end else if (win_v && win_p < r_r.cur_prio) begin
                    // late arrival swaps vector, entry continues
                    r_nxt.req_id   = win_id;
                    r_nxt.cur_id   = win_id;
                    r_nxt.cur_prio = win_p;
                end
            end
            ismp_pkg::ST_ACTIVE: begin
                if (cpu_eoi) begin
                    r_nxt.st = ismp_pkg::ST_IDLE;
                end
            end
            default: r_nxt.st = ismp_pkg::ST_IDLE;
        endcase
    end

    // single state register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r_r <= '0;
        end else if (clk_en) begin
            r_r <= r_nxt;
        end
    end

    assign irq_req   = r_r.req;
    assign irq_id    = r_r.req_id;
    assign irq_taken = r_r.taken;

    // entry steps: a winner in idle, then the core's ack
    sequence entry_start_s;
        clk_en && r_r.st == ismp_pkg::ST_IDLE && win_v;
    endsequence
    sequence entry_ack_s;
        clk_en && r_r.st == ismp_pkg::ST_ENTRY && cpu_ack;
    endsequence
    // a raw flag reaches pend after two sync edges and the pend edge
    sequence sync_path_s;
        clk_en ##1 clk_en;
    endsequence
    property entry_req_p;
        @(posedge clk_sys) disable iff (!resetn)
        entry_start_s |=> irq_req;
    endproperty
    req_on_pend_a: assert property (entry_req_p)
        else $error("pending line gave no request");

    pend_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && lines != '0) |=> ((r_r.pend & $past(lines)) == $past(lines)))
        else $error("asserted source not latched pending");

    // mapping: raw flag at the pin to pending bit of its line
    line_or_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && (|src.sync_serial_port_b)) ##1 sync_path_s |=> r_r.pend[ismp_pkg::LINE_SSPB])
        else $error("serial port b flag not pending on its line");

    can_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && src.can_irq) ##1 sync_path_s |=> r_r.pend[ismp_pkg::LINE_CAN] == HAS_CAN)
        else $error("can line does not follow can variant");

    mask_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        win_v && mask_on |-> win_p < mask_lvl)
        else $error("masked priority won arbitration");

    win_valid_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        win_v |-> r_r.pend[win_id] && line_en[win_id])
        else $error("winner not a pending enabled line");

    // handshake with the core
    late_swap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && r_r.st == ismp_pkg::ST_ENTRY && !cpu_ack && win_v && win_p < r_r.cur_prio)
        |=> irq_id == $past(win_id) && r_r.st == ismp_pkg::ST_ENTRY)
        else $error("late higher request not taken over");

    entry_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && r_r.st == ismp_pkg::ST_ENTRY && !cpu_ack) |=> r_r.st == ismp_pkg::ST_ENTRY && irq_req)
        else $error("entry dropped before ack");

    taken_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        entry_ack_s |=> irq_taken && !irq_req)
        else $error("entry ack not reflected");

    taken_once_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && irq_taken) |=> !irq_taken)
        else $error("taken pulse longer than one cycle");

    ack_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        entry_ack_s |=> r_r.pend[$past(r_r.cur_id)] == $past(lines[r_r.cur_id]))
        else $error("serviced line pending bit wrong after ack");

    eoi_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && r_r.st == ismp_pkg::ST_ACTIVE && cpu_eoi) |=> r_r.st == ismp_pkg::ST_IDLE)
        else $error("handler return did not free the core");

    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        r_r.st == ismp_pkg::ST_IDLE |-> !irq_req)
        else $error("request raised while idle");

    gpio_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && src.gpio_port_irq[ismp_pkg::GPIO_N-1]) ##1 sync_path_s
        |=> r_r.pend[ismp_pkg::LINE_GPIO3])
        else $error("gpio port 3 not on its line");

    wake_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && src.port1_pin0_wake) ##1 sync_path_s |=> r_r.pend[ismp_pkg::LINE_WAKE1])
        else $error("port1 wake pin not on line 12");

    wake0_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clk_en && src.port0_wake != '0) ##1 sync_path_s
        |=> (r_r.pend[ismp_pkg::WAKE_P0_N-1:0] & $past(src.port0_wake, 3))
            == $past(src.port0_wake, 3))
        else $error("port0 wake pins not on lines 0-11");
endmodule
`default_nettype wire

/* shared/ismp_pkg.sv */
package ismp_pkg;
    localparam int NUM_LINES   = 32;
    localparam int PRIO_W      = 2;
    localparam int ID_W        = 5;
    localparam int WAKE_P0_N   = 12;
    localparam int LINE_WAKE1  = 12;
    localparam int LINE_CAN    = 13;
    localparam int LINE_SSPB   = 14;
    localparam int LINE_TWI    = 15;
    localparam int LINE_TMR16A = 16;
    localparam int LINE_TMR16B = 17;
    localparam int LINE_TMR32A = 18;
    localparam int LINE_TMR32B = 19;
    localparam int LINE_SSPA   = 20;
    localparam int LINE_UART   = 21;
    localparam int LINE_ADC    = 24;
    localparam int LINE_WDT    = 25;
    localparam int LINE_BOD    = 26;
    localparam int LINE_GPIO3  = 28;
    localparam int GPIO_N      = 4;
    localparam int SSP_FLAGS   = 4;
    localparam int UART_FLAGS  = 6;
    localparam logic [PRIO_W-1:0] PRIO_NONE = 2'h3;

    // peripheral source flags as they arrive
    typedef struct packed {
        logic [WAKE_P0_N-1:0]  port0_wake;
        logic                  port1_pin0_wake;
        logic                  can_irq;
        logic [SSP_FLAGS-1:0]  sync_serial_port_b;
        logic                  twi_state_chg;
        logic [SSP_FLAGS-1:0]  tmr16a;
        logic [SSP_FLAGS-1:0]  tmr16b;
        logic [SSP_FLAGS-1:0]  tmr32a;
        logic [SSP_FLAGS-1:0]  tmr32b;
        logic [SSP_FLAGS-1:0]  sync_serial_port_a;
        logic [UART_FLAGS-1:0] uart;
        logic                  adc_done;
        logic                  wdt_irq;
        logic                  bod_irq;
        logic [GPIO_N-1:0]     gpio_port_irq;
    } ismp_src_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_ACTIVE} ismp_state_t;

    typedef struct packed {
        ismp_src_t            src_s1;
        ismp_src_t            src_s2;
        logic [NUM_LINES-1:0] pend;
        ismp_state_t          st;
        logic [ID_W-1:0]      cur_id;
        logic [PRIO_W-1:0]    cur_prio;
        logic                 req;
        logic [ID_W-1:0]      req_id;
        logic                 taken;
    } ismp_regs_t;
endpackage

/* test/ismp_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// core side: takes one request at a time, acks after ack_dly cycles
module ismp_core_model (
    input  wire logic                      clk_sys, // system clock
    input  wire logic                      irq_req, // request from block
    input  wire logic [ismp_pkg::ID_W-1:0] irq_id,  // vector offered
    input  wire logic [7:0]                ack_dly, // entry wait, cycles
    output logic                           cpu_ack, // entry done pulse
    output logic                           cpu_eoi, // handler return pulse
    output logic [ismp_pkg::ID_W-1:0]      got_id,  // vector taken at ack
    output int                             served   // handlers finished
);
    // no nesting, so ack and eoi never land outside entry or active
    initial begin
        cpu_ack = 1'b0;
        cpu_eoi = 1'b0;
        got_id  = '0;
        served  = 0;
        forever begin
            @(posedge clk_sys);
            if (irq_req === 1'b1) begin
                repeat (ack_dly) @(posedge clk_sys);
                cpu_ack <= 1'b1;
                @(negedge clk_sys);
                got_id = irq_id; // a late winner has already replaced it
                @(posedge clk_sys);
                cpu_ack <= 1'b0;
                repeat (2) @(posedge clk_sys);
                cpu_eoi <= 1'b1;
                @(posedge clk_sys);
                cpu_eoi <= 1'b0;
                served++;
            end
        end
    end
endmodule
`default_nettype wire

/* test/irq_source_mapping_prioritizer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_source_mapping_prioritizer_tb_top;
    logic                             clk_sys, resetn, mask_on;
    logic                             cpu_ack, cpu_eoi, irq_req, irq_taken;
    ismp_pkg::ismp_src_t              src;
    logic [ismp_pkg::NUM_LINES-1:0]   line_en;
    logic [2*ismp_pkg::NUM_LINES-1:0] line_prio;
    logic [ismp_pkg::PRIO_W-1:0]      mask_lvl;
    logic [ismp_pkg::ID_W-1:0]        irq_id, got_id;
    logic [7:0]                       ack_dly;
    logic [31:0]                      pend_clr;
    int                               served, seen, num_errors, n_checks, cycles, n_taken;

    ismp_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .src(src),
        .line_en(line_en), .line_prio(line_prio), .mask_lvl(mask_lvl), .mask_on(mask_on),
        .pend_clr(pend_clr), .cpu_ack(cpu_ack), .cpu_eoi(cpu_eoi),
        .irq_req(irq_req), .irq_id(irq_id), .irq_taken(irq_taken));
    ismp_core_model core (.clk_sys(clk_sys), .irq_req(irq_req), .irq_id(irq_id),
        .ack_dly(ack_dly), .cpu_ack(cpu_ack), .cpu_eoi(cpu_eoi), .got_id(got_id),
        .served(served));

    // place each line's flag; OR-ed lines other than 16 (tmr16a bit 0) get a flag other than bit 0
    function automatic ismp_pkg::ismp_src_t with_lines(ismp_pkg::ismp_src_t s,
                                                        logic [31:0] m, logic v);
        for (int i = 0; i < 32; i++) begin
            if (m[i]) begin
                case (i) inside
                    [0:11]:  s.port0_wake[i] = v;
                    12:      s.port1_pin0_wake = v;
                    13:      s.can_irq = v;
                    14:      s.sync_serial_port_b[3] = v;
                    15:      s.twi_state_chg = v;
                    16:      s.tmr16a[0] = v;
                    17:      s.tmr16b[1] = v;
                    18:      s.tmr32a[2] = v;
                    19:      s.tmr32b[3] = v;
                    20:      s.sync_serial_port_a[1] = v;
                    21:      s.uart[5] = v;
                    24:      s.adc_done = v;
                    25:      s.wdt_irq = v;
                    26:      s.bod_irq = v;
                    default: s.gpio_port_irq[31-i] = v;
                endcase
            end
        end
        return s;
    endfunction

    task check(logic [ismp_pkg::ID_W-1:0] got, logic [ismp_pkg::ID_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // short pulse: the block must latch it, the source will not wait
    task pulse(logic [31:0] m);
        @(posedge clk_sys);
        src <= with_lines(src, m, 1'b1);
        repeat (2) @(posedge clk_sys);
        src <= with_lines(src, m, 1'b0);
    endtask

    task expect_id(logic [ismp_pkg::ID_W-1:0] exp);
        for (int k = 0; k < 300 && served <= seen; k++) @(posedge clk_sys);
        // a request the core never finished is a hang, not a pass
        if (served <= seen) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, served, seen + 1);
        end
        seen++;
        check(got_id, exp);
    endtask

    task t_map;
        for (int i = 0; i < 32; i++) begin
            if (i != 22 && i != 23 && i != 27) begin
                pulse(32'h1 << i);
                expect_id(i[4:0]);
            end
        end
    endtask

    task t_prio;
        @(posedge clk_sys);
        line_prio[61:60] <= 2'h0;
        line_prio[7:6] <= 2'h2;
        pulse(32'h4000_0008);
        expect_id(5'h1E);
        expect_id(5'h03);
        pulse(32'h0000_0120);
        expect_id(5'h05);
        expect_id(5'h08);
    endtask

    task t_mask;
        @(posedge clk_sys);
        mask_lvl <= 2'h1;
        mask_on <= 1'b1;
        pulse(32'h0000_0080);
        repeat (20) @(posedge clk_sys);
        check({4'h0, irq_req}, 5'h00);
        mask_on <= 1'b0;
        expect_id(5'h07);
    endtask

    // slow core: a more urgent line arrives while entry is under way
    task t_late;
        @(posedge clk_sys);
        ack_dly <= 8'h0C;
        line_prio[41:40] <= 2'h0;
        pulse(32'h0000_0200);
        for (int k = 0; k < 50 && irq_req !== 1'b1; k++) @(posedge clk_sys);
        pulse(32'h0010_0000);
        expect_id(5'h14);
        expect_id(5'h09);
    endtask

    // a masked line cleared by software must never reach the core
    task t_clear;
        @(posedge clk_sys);
        mask_on <= 1'b1;
        pulse(32'h0000_0040);
        repeat (4) @(posedge clk_sys);
        pend_clr <= 32'h0000_0040;
        @(posedge clk_sys);
        pend_clr <= 32'h0000_0000;
        mask_on <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check({4'h0, irq_req}, 5'h00);
        check(served[4:0], seen[4:0]);
    endtask

    // as many taken pulses were counted as entries finished
    task t_taken;
        n_checks++;
        if (n_taken != served) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, n_taken, served);
        end
    endtask

    task complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // taken pulses counted mid-cycle, where the one-cycle pulse is settled
    always @(negedge clk_sys) begin
        if (irq_taken === 1'b1) begin
            n_taken++;
        end
    end

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        resetn = 1'b0;
        src = '0;
        line_en = 32'hFFFF_FFFF;
        line_prio = {32{2'h1}};
        mask_lvl = 2'h0;
        mask_on = 1'b0;
        ack_dly = 8'h02;
        pend_clr = 32'h0000_0000;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_map();
        t_prio();
        t_mask();
        t_clear();
        t_late();
        t_taken();
        complete_run();
    end
endmodule
`default_nettype wire
